// File: design/rsr_recorder.sv
// Purpose: reset source recorder and reset sequencer with APB access
// Assumes: all source inputs synchronous to pclk; presetn is the power-on reset
// Notes:   status byte sits in bits 7:0 of the word at RCS_OFFSET
//
// Overview of operation
// - writing 1 to soft force bit resets system; 0 does nothing; flag reads 1 after
// - software reset never drives the external reset pin
// - bit 7 reads zero, writes ignored
// - flash fault flag read-only, set only when last reset was a flash fault
// - comparator enable bit makes low comparator output a reset source
// - comparator bit reads 1 only if comparator caused last reset
// - watchdog flag read-only, 1 exactly when watchdog caused last reset
// - clock-loss bit written 1 enables detection, 0 disables it
// - clock-loss bit reads 1 only if clock loss caused last reset
// - detector resets after timeout without a rising system clock edge
// - power-on flag set by power-on and supply-monitor resets
// - writing power-on flag position enables or disables supply monitor
// - other cause flags meaningless while power-on flag reads 1
// - pin flag read-only, 1 exactly when the reset pin caused last reset
// - at least the reset delay passes after release before execution
// - enabling the monitor resets once; rewriting 1 when enabled does not
// - power-on reset disables monitor; other resets keep its state
// - any reset other than power-on, supply-monitor or monitor-enable clears the power-on flag
// - flash fault reset sets its flag and leaves the pin undriven

`timescale 1ns/1ps

module rsr_recorder
   import rsr_pkg::*;
#(
   parameter int LOSS_TIMEOUT_CYC = LOSS_MIN_CYC
) (
   // clock and power-on reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // external reset pin, open drain
   input wire logic rst_pin_i,
   output logic rst_pin_o,
   output logic rst_pin_oe,
   // on-chip reset sources
   input wire logic comp_out,
   input wire logic vdd_low,
   input wire logic watchdog_timeout,
   input wire logic flash_fault,
   input wire logic sysclk_smp,
   // system reset, low while the system is held
   output logic sys_rst_n
);

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   rsr_state_e state_q;
   logic [DLY_W-1:0] dly_q;
   logic [CAUSE_W-1:0] cause_q;
   logic comp_en_q;
   logic loss_en_q;
   logic mon_en_q;
   logic pin_mask_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic rst_pin_oe_q;
   logic rst_pin_o_q;
   logic sys_rst_n_q;
   logic setup;
   logic hit;
   logic wr_acc;
   logic pin_low;
   logic comp_low;
   logic mon_low;
   logic level_hold;
   logic mon_turn_on;
   logic [CAUSE_W-1:0] trig;
   logic [CAUSE_W-1:0] pick;

   rsr_clkmon_if clk_if ();

   // highest priority first: supply, pin, comparator, clock, flash, watchdog, software
   function automatic logic [CAUSE_W-1:0] first_cause(input logic [CAUSE_W-1:0] t);
      logic [CAUSE_W-1:0] r;
      r = '0;
      if (t[BIT_POR]) begin
         r[BIT_POR] = 1'h1;
      end else if (t[BIT_PIN]) begin
         r[BIT_PIN] = 1'h1;
      end else if (t[BIT_COMP]) begin
         r[BIT_COMP] = 1'h1;
      end else if (t[BIT_CLK]) begin
         r[BIT_CLK] = 1'h1;
      end else if (t[BIT_FLASH]) begin
         r[BIT_FLASH] = 1'h1;
      end else if (t[BIT_WATCHDOG]) begin
         r[BIT_WATCHDOG] = 1'h1;
      end else if (t[BIT_SOFT]) begin
         r[BIT_SOFT] = 1'h1;
      end
      return r;
   endfunction

   // ---------------------------------------------------------------
   // apb slave, one wait-free access phase, registered answer
   // ---------------------------------------------------------------
   assign setup = psel & ~penable;
   assign hit = (paddr == RCS_OFFSET);
   assign wr_acc = psel & penable & pready_q & pwrite & hit & pstrb[0];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'h0;
         pslverr_q <= 1'h0;
         prdata_q <= 32'h0;
      end else begin
         pready_q <= setup;
         pslverr_q <= setup & ~hit;
         // flags only: enables are write-side state and never read back
         if (setup && !pwrite && hit) begin
            prdata_q <= {24'h0, 1'h0, cause_q};
         end else begin
            prdata_q <= 32'h0;
         end
      end
   end

   // ---------------------------------------------------------------
   // enable bits
   // ---------------------------------------------------------------
   // async reset is the power-on reset, the only one that clears these
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         comp_en_q <= 1'h0;
         loss_en_q <= 1'h0;
         mon_en_q <= 1'h0;
      end else if (wr_acc) begin
         comp_en_q <= pwdata[BIT_COMP];
         loss_en_q <= pwdata[BIT_CLK];
         mon_en_q <= pwdata[BIT_POR];
      end
   end

   // ---------------------------------------------------------------
   // reset sources
   // ---------------------------------------------------------------
   // our own drive of the pin must not read back as an external reset
   assign pin_low = ~rst_pin_i & ~rst_pin_oe_q & ~pin_mask_q;
   assign comp_low = comp_en_q & ~comp_out;
   assign mon_low = mon_en_q & vdd_low;
   assign level_hold = pin_low | comp_low | mon_low;
   assign mon_turn_on = wr_acc & pwdata[BIT_POR] & ~mon_en_q;
   assign clk_if.arm = loss_en_q & (state_q == ST_RUN);

   always_comb begin
      trig = '0;
      trig[BIT_POR] = mon_low | mon_turn_on;
      trig[BIT_PIN] = pin_low;
      trig[BIT_COMP] = comp_low;
      trig[BIT_CLK] = clk_if.timeout;
      trig[BIT_FLASH] = flash_fault;
      trig[BIT_WATCHDOG] = watchdog_timeout;
      trig[BIT_SOFT] = wr_acc & pwdata[BIT_SOFT];
      pick = first_cause(trig);
   end

   rsr_clkmon #(
      .TIMEOUT_CYC(LOSS_TIMEOUT_CYC)
   ) u_clkmon (
      .pclk(pclk),
      .presetn(presetn),
      .sysclk_smp(sysclk_smp),
      .mon(clk_if.mon)
   );

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_DELAY;
         dly_q <= DLY_W'(RST_DELAY_CYC - 1);
      end else begin
         case (state_q)
            ST_RUN: begin
               if (trig != '0) begin
                  state_q <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               dly_q <= DLY_W'(RST_DELAY_CYC - 1);
               if (!level_hold) begin
                  state_q <= ST_DELAY;
               end
            end
            ST_DELAY: begin
               if (level_hold) begin
                  state_q <= ST_HOLD;
               end else if (dly_q == '0) begin
                  state_q <= ST_RUN;
               end else begin
                  dly_q <= dly_q - DLY_W'(1);
               end
            end
            default: begin
               state_q <= ST_HOLD;
            end
         endcase
      end
   end

   // cause is latched once, on entry to reset; other flags cleared
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cause_q <= CAUSE_RESET;
      end else if (state_q == ST_RUN && trig != '0) begin
         cause_q <= pick;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_rst_n_q <= 1'h0;
         rst_pin_oe_q <= 1'h1;
         rst_pin_o_q <= 1'h0;
         pin_mask_q <= 1'h1;
      end else begin
         sys_rst_n_q <= (state_q == ST_RUN);
         // only power-on class resets pull the pin
         rst_pin_oe_q <= (state_q != ST_RUN) && cause_q[BIT_POR];
         rst_pin_o_q <= 1'h0;
         pin_mask_q <= rst_pin_oe_q;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign rst_pin_oe = rst_pin_oe_q;
   assign rst_pin_o = rst_pin_o_q;
   assign sys_rst_n = sys_rst_n_q;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic [DLY_W:0] low_cnt_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_cnt_q <= '0;
      end else if (sys_rst_n_q) begin
         low_cnt_q <= '0;
      end else if (low_cnt_q != '1) begin
         low_cnt_q <= low_cnt_q + (DLY_W + 1)'(1);
      end
   end

   a_sw_force_reset: assert property (
      (state_q == ST_RUN && wr_acc && pwdata[BIT_SOFT]) |-> ##[1:2] !sys_rst_n_q)
      else $error("software force did not reset the system");

   a_sw_flag_only: assert property (
      (state_q == ST_RUN && trig == (CAUSE_W'(1) << BIT_SOFT))
      |=> cause_q == (CAUSE_W'(1) << BIT_SOFT))
      else $error("software reset did not set only its flag");

   a_sw_pin_free: assert property (
      (cause_q[BIT_SOFT] || cause_q[BIT_FLASH]) |-> !rst_pin_oe_q)
      else $error("reset pin driven for a software or flash reset");

   a_top_bit_zero: assert property (
      pready_q |-> prdata_q[31:BIT_UNUSED] == '0)
      else $error("unused status bits read nonzero");

   a_cause_onehot: assert property (
      (state_q == ST_RUN && trig != '0) |=> state_q == ST_HOLD && $onehot(cause_q))
      else $error("reset entry did not record exactly one cause");

   a_comp_source: assert property (
      (state_q == ST_RUN && comp_en_q && !comp_out && !mon_low && !pin_low && !mon_turn_on)
      |=> cause_q == (CAUSE_W'(1) << BIT_COMP))
      else $error("comparator low did not reset with its flag");

   a_clk_loss_cause: assert property (
      (state_q == ST_RUN && clk_if.timeout && !level_hold && !mon_turn_on)
      |=> cause_q[BIT_CLK] ##[1:2] !sys_rst_n_q)
      else $error("clock-loss timeout did not reset with its flag");

   a_clk_disarmed: assert property (
      !loss_en_q |-> ##2 !clk_if.timeout)
      else $error("clock-loss timeout while detection disabled");

   a_mon_cause: assert property (
      (state_q == ST_RUN && mon_low) |=> cause_q == (CAUSE_W'(1) << BIT_POR)
      ##1 rst_pin_oe_q)
      else $error("supply monitor reset did not set the power-on flag or pull the pin");

   a_mon_enable: assert property (
      (state_q == ST_RUN && mon_turn_on) |=> state_q == ST_HOLD && mon_en_q)
      else $error("enabling the supply monitor did not reset");

   a_mon_rewrite: assert property (
      (state_q == ST_RUN && wr_acc && mon_en_q && !pwdata[BIT_SOFT] && !level_hold
       && !clk_if.timeout && !flash_fault && !watchdog_timeout) |=> state_q == ST_RUN)
      else $error("rewriting an enabled supply monitor caused a reset");

   a_mon_kept: assert property (
      (state_q != ST_RUN && !wr_acc) |=> $stable(mon_en_q))
      else $error("supply monitor enable changed by a reset");

   a_pin_cause: assert property (
      (state_q == ST_RUN && pin_low && !mon_low && !mon_turn_on)
      |=> cause_q == (CAUSE_W'(1) << BIT_PIN))
      else $error("pin reset did not set only the pin flag");

   a_exec_delay: assert property (
      $rose(sys_rst_n_q) |-> $past(low_cnt_q) >= (DLY_W + 1)'(RST_DELAY_CYC))
      else $error("system released before the reset delay");

endmodule // rsr_recorder

// File: design/rsr_pkg.sv
// Purpose: shared constants and types of the reset source recorder
// Assumes: pclk at 50 MHz
// Notes:   one 8-bit status/control register on APB, low byte of the word

package rsr_pkg;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_FREQ_MHZ = 50;
   // least delay from release of a reset source to code execution, 5.0 us
   localparam int RST_DELAY_NS = 5000;
   localparam int RST_DELAY_CYC = (RST_DELAY_NS * CLK_FREQ_MHZ + 999) / 1000;
   // clock-loss timeout window, 100 us .. 500 us
   localparam int LOSS_MIN_US = 100;
   localparam int LOSS_MAX_US = 500;
   localparam int LOSS_MIN_CYC = LOSS_MIN_US * CLK_FREQ_MHZ;
   localparam int LOSS_MAX_CYC = LOSS_MAX_US * CLK_FREQ_MHZ;
   localparam int DLY_W = 9;
   localparam int LOSS_W = 15;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] RCS_OFFSET = 8'h00;
   localparam int CAUSE_W = 7;
   localparam int BIT_PIN = 0;
   localparam int BIT_POR = 1;
   localparam int BIT_CLK = 2;
   localparam int BIT_WATCHDOG = 3;
   localparam int BIT_SOFT = 4;
   localparam int BIT_COMP = 5;
   localparam int BIT_FLASH = 6;
   localparam int BIT_UNUSED = 7;
   // value of the cause flags after a power-on reset
   localparam logic [CAUSE_W-1:0] CAUSE_RESET = 7'h02;

   // ---------------------------------------------------------------
   // sequencer states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_HOLD = 2'b01,
      ST_DELAY = 2'b10
   } rsr_state_e;

endpackage

// File: design/rsr_clkmon_if.sv
// Purpose: link between the sequencer and the clock-loss detector
// Assumes: single pclk domain
// Notes:   arm is high only while detection is enabled and the system runs

`timescale 1ns/1ps

interface rsr_clkmon_if;
   logic arm;
   logic timeout;
   modport ctl (output arm, input timeout);
   modport mon (input arm, output timeout);
endinterface

// File: design/rsr_clkmon.sv
// Purpose: clock-loss detector, counts pclk cycles since the last
//          rising edge of the sampled system clock
// Assumes: sysclk_smp is synchronous to pclk
// Notes:   timeout is a one-cycle pulse

`timescale 1ns/1ps

module rsr_clkmon
   import rsr_pkg::*;
#(
   parameter int TIMEOUT_CYC = LOSS_MIN_CYC
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // sampled system clock
   input wire logic sysclk_smp,
   // sequencer side
   rsr_clkmon_if.mon mon
);

   localparam logic [LOSS_W-1:0] LIMIT = LOSS_W'(TIMEOUT_CYC - 1);

   logic smp_prev_q;
   logic [LOSS_W-1:0] cnt_q;
   logic to_q;
   logic rise;

   assign rise = sysclk_smp & ~smp_prev_q;
   assign mon.timeout = to_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         smp_prev_q <= 1'h0;
      end else begin
         smp_prev_q <= sysclk_smp;
      end
   end

   // a rising edge restarts the one-shot
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
      end else if (!mon.arm || rise || to_q) begin
         cnt_q <= '0;
      end else if (cnt_q != LIMIT) begin
         cnt_q <= cnt_q + LOSS_W'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         to_q <= 1'h0;
      end else begin
         to_q <= mon.arm && !rise && !to_q && (cnt_q == LIMIT);
      end
   end

   a_loss_edge_clears: assert property (@(posedge pclk) disable iff (!presetn)
      (rise || !mon.arm) |=> !to_q ##1 !to_q)
      else $error("clock-loss timeout soon after a clock edge or while disarmed");

endmodule // rsr_clkmon

// File: verif/rsr_far_model.sv
// Purpose: far side of the recorder: reset pin with pull-up, system clock
// Assumes: pclk domain, the system clock toggles once per pclk while running
// Notes:   pin reads high unless a party pulls it low

`timescale 1ns/1ps

module rsr_far_model (
   // clock
   input wire logic pclk,
   // bench controls
   input wire logic clk_run,
   input wire logic ext_pull,
   // recorder pin and clock side
   input wire logic rst_pin_o,
   input wire logic rst_pin_oe,
   output logic rst_pin_i,
   output logic sysclk_smp
);
   // open drain: either party pulls low, the pull-up wins otherwise
   assign rst_pin_i = ~((rst_pin_oe & ~rst_pin_o) | ext_pull);

   // a stopped clock stands at its last level, as a lost oscillator would
   initial sysclk_smp = 1'b0;
   always @(posedge pclk) begin
      if (clk_run) begin
         sysclk_smp <= ~sysclk_smp;
      end
   end
endmodule // rsr_far_model

// File: verif/tb_top.sv
// Purpose: self-checking bench of the reset source recorder
// Assumes: APB master in the bench, behavioural model of the status byte
// Notes:   clock-loss timeout shortened to LOSS_T cycles

`timescale 1ns/1ps

module tb_top;
   import rsr_pkg::*;
   localparam int LOSS_T = 20;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] prdata;
   logic pready, pslverr, rst_pin_i, rst_pin_o, rst_pin_oe, sysclk_smp, sys_rst_n;
   logic comp_out = 1'b1;
   logic vdd_low = 1'b0;
   logic watchdog_timeout = 1'b0;
   logic flash_fault = 1'b0;
   logic clk_run = 1'b1;
   logic ext_pull = 1'b0;
   int err_total = 0;
   int samples_checked = 0;
   int m_cause = 2;
   int m_mon = 0;
   int pin_seen = 0;
   logic [31:0] seed = 32'hA2DBD3AE;

   always #10 pclk = ~pclk;

   rsr_recorder #(.LOSS_TIMEOUT_CYC(LOSS_T)) uut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe),
      .comp_out(comp_out), .vdd_low(vdd_low), .watchdog_timeout(watchdog_timeout),
      .flash_fault(flash_fault), .sysclk_smp(sysclk_smp), .sys_rst_n(sys_rst_n));

   rsr_far_model fm (.pclk(pclk), .clk_run(clk_run), .ext_pull(ext_pull),
      .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .rst_pin_i(rst_pin_i),
      .sysclk_smp(sysclk_smp));

   // a lost clock comes back once the reset has been taken
   always @(posedge pclk) begin
      if (sys_rst_n === 1'b0) begin
         clk_run <= 1'b1;
      end
      if (rst_pin_oe === 1'b1) begin
         pin_seen = 1;
         check("pin_level", rst_pin_o, 0);
      end
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input int exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one transfer; entered and left just after a rising edge
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n == 50) begin
         err_total++;
         final_report();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // model of a software write; returns 1 where the write starts a reset
   task automatic m_write(input logic [31:0] d, output int rst);
      rst = 0;
      if (d[BIT_POR] && m_mon == 0) begin
         rst = 1;
         m_cause = 32'h02;
      end else if (d[BIT_SOFT]) begin
         rst = 1;
         m_cause = 32'h10;
      end
      m_mon = d[BIT_POR];
   endtask

   task automatic expect_reset(input int yes, input int drv, output int n);
      int m;
      logic [31:0] v;
      logic e;
      n = 0;
      while (sys_rst_n === 1'b1 && n < 40) begin
         @(posedge pclk);
         n++;
      end
      check("reset_taken", sys_rst_n !== 1'b1, yes);
      if (yes != 0) begin
         m = 0;
         while (sys_rst_n !== 1'b1 && m < 600) begin
            @(posedge pclk);
            m++;
         end
         if (m == 600) begin
            err_total++;
            final_report();
         end
         check("held_cycles", m >= RST_DELAY_CYC, 1);
      end
      check("pin_driven", pin_seen, drv);
      apb(1'b0, RCS_OFFSET, 32'h0, v, e);
      check("status_err", e, 0);
      check("status", v, m_cause);
      pin_seen = 0;
   endtask

   task automatic wr_exp(input logic [31:0] d);
      int r;
      int n;
      logic [31:0] v;
      logic e;
      m_write(d, r);
      apb(1'b1, RCS_OFFSET, d, v, e); // plain write, no read-modify-write
      expect_reset(r, (r != 0 && m_cause == 2) ? 1 : 0, n);
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      int n;
      logic [31:0] v;
      logic e;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      expect_reset(1, 1, n);
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         apb(1'b1, {seed[7:2], 2'b00} | 8'h04, 32'h10, v, e);
         check("err_unmapped", e, 1);
         apb(1'b0, {seed[9:4], 2'b00} | 8'h04, 32'h0, v, e);
         check("rd_unmapped", v, 0);
         seed = xs(seed);
         wr_exp(seed & 32'hFFFFFFC9);
      end
      pstrb <= 4'h0;
      apb(1'b1, RCS_OFFSET, 32'h10, v, e);
      pstrb <= 4'hF;
      expect_reset(0, 0, n);
      wr_exp(32'h10);
      wr_exp(32'h00);
      m_cause = 32'h08;
      watchdog_timeout <= 1'b1;
      @(posedge pclk);
      watchdog_timeout <= 1'b0;
      expect_reset(1, 0, n);
      m_cause = 32'h40;
      flash_fault <= 1'b1;
      @(posedge pclk);
      flash_fault <= 1'b0;
      expect_reset(1, 0, n);
      m_cause = 32'h01;
      ext_pull <= 1'b1;
      repeat (5) @(posedge pclk);
      ext_pull <= 1'b0;
      expect_reset(1, 0, n);
      comp_out <= 1'b0;
      expect_reset(0, 0, n);
      comp_out <= 1'b1;
      wr_exp(32'h20);
      m_cause = 32'h20;
      comp_out <= 1'b0;
      repeat (3) @(posedge pclk);
      comp_out <= 1'b1;
      expect_reset(1, 0, n);
      wr_exp(32'h04);
      m_cause = 32'h04;
      clk_run <= 1'b0;
      expect_reset(1, 0, n);
      check("loss_early", n >= LOSS_T - 2, 1);
      check("loss_late", n <= LOSS_T + 4, 1);
      wr_exp(32'h00);
      clk_run <= 1'b0;
      expect_reset(0, 0, n);
      clk_run <= 1'b1;
      wr_exp(32'h02);
      wr_exp(32'h02);
      wr_exp(32'h12);
      m_cause = 32'h02;
      vdd_low <= 1'b1;
      repeat (3) @(posedge pclk);
      vdd_low <= 1'b0;
      expect_reset(1, 1, n);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      m_mon = 0;
      expect_reset(1, 1, n);
      vdd_low <= 1'b1;
      expect_reset(0, 0, n);
      vdd_low <= 1'b0;
      final_report();
   end
endmodule // tb_top
